// >>> rtl/clock_ratio_pkg.sv
// Constants, tables and carrier types for the clock ratio strap decoder
package clock_ratio_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] STRAP_STATUS_OFFSET = 4'h0;
    localparam logic [3:0] CLOCK_CONTROL_OFFSET = 4'h4;
    localparam logic [3:0] RATIO_OFFSET = 4'h8;
    localparam int         ADDR_WIDTH = 4;

    // Strap status fields
    localparam int STATUS_PLATFORM_CODE_LSB = 0;
    localparam int STATUS_CORE0_CODE_LSB = 3;
    localparam int STATUS_CORE1_CODE_LSB = 6;
    localparam int STATUS_MEMORY_CODE_LSB = 9;
    localparam int STATUS_CAPTURED_BIT = 12;
    localparam int STATUS_PLATFORM_RESERVED_BIT = 13;
    localparam int STATUS_CORE0_RESERVED_BIT = 14;
    localparam int STATUS_CORE1_RESERVED_BIT = 15;
    localparam int STATUS_SYNC_MODE_BIT = 16;

    // Clock control fields
    localparam int   CONTROL_MEMORY_CLOCK_ENABLE_BIT = 0;
    localparam logic CONTROL_MEMORY_CLOCK_ENABLE_RESET = 1'b1;

    // Ratio register fields
    localparam int RATIO_PLATFORM_LSB = 0;
    localparam int RATIO_CORE0_LSB = 8;
    localparam int RATIO_CORE1_LSB = 16;
    localparam int RATIO_MEMORY_LSB = 24;

    // Cycles after reset release before the strap sample is trusted
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Platform : reference ratio, whole multiples; zero marks reserved
    localparam logic [7:0] PLATFORM_RATIO_TABLE [8] = '{
        8'h04, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h00, 8'h00};
    // Core : platform ratio in halves (3 means 3:2); zero marks reserved
    localparam logic [7:0] CORE_RATIO_X2_TABLE [8] = '{
        8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    // DDR data rate : memory reference ratio; last code is synchronous mode
    localparam logic [7:0] MEMORY_RATIO_TABLE [8] = '{
        8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h00};
    localparam logic [2:0] MEMORY_SYNC_CODE = 3'h7;

    typedef struct packed {
        logic       captured;
        logic [7:0] platform_ratio;
        logic       platform_reserved;
        logic [7:0] core0_ratio_x2;
        logic       core0_reserved;
        logic [7:0] core1_ratio_x2;
        logic       core1_reserved;
        logic [7:0] memory_ratio;
        logic       memory_sync_mode;
    } clock_config_t;

    typedef struct packed {
        logic [2:0] platform;
        logic [2:0] core0;
        logic [2:0] core1;
        logic [2:0] memory;
    } strap_codes_t;

endpackage

// >>> rtl/clock_ratio_strap_decoder.sv
// Strap capture, clock ratio decode and AXI4-Lite status/control slave
`timescale 1ns/10ps
`default_nettype none

module clock_ratio_strap_decoder (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [2:0]                    platform_ratio_strap,
    input  wire logic                          core0_ratio_strap_bit0,
    input  wire logic                          core0_ratio_strap_bit1,
    input  wire logic                          core0_ratio_strap_bit2,
    input  wire logic                          core1_ratio_strap_bit0,
    input  wire logic                          core1_ratio_strap_bit1,
    input  wire logic                          core1_ratio_strap_bit2,
    input  wire logic                          memory_ratio_strap_bit0,
    input  wire logic                          memory_ratio_strap_bit1,
    input  wire logic                          memory_ratio_strap_bit2,
    output var  clock_ratio_pkg::clock_config_t clock_config,
    output logic                               memory_bus_clock_out,
    output logic                               memory_pll_enable,
    input  wire logic [3:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [3:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);

    typedef struct packed {
        clock_ratio_pkg::strap_codes_t  meta;
        clock_ratio_pkg::strap_codes_t  sync;
        logic [1:0]                     settle_cnt;
        clock_ratio_pkg::strap_codes_t  codes;
        clock_ratio_pkg::clock_config_t cfg;
        logic                           mem_clk_enable;
        logic                           mck;
        logic                           aw_held;
        logic [3:0]                     awaddr;
        logic                           w_held;
        logic [31:0]                    wdata;
        logic                           wstrb0;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
    } state_t;

    localparam state_t RESET_STATE = '{
        mem_clk_enable: clock_ratio_pkg::CONTROL_MEMORY_CLOCK_ENABLE_RESET,
        default: '0};

    state_t st_reg;
    state_t st_next;
    logic   [31:0] status_word;
    logic   [31:0] ratio_word;
    clock_ratio_pkg::strap_codes_t pins;

    // First-named pin of each group is the code's MSB
    assign pins = '{
        platform: platform_ratio_strap,
        core0:    {core0_ratio_strap_bit0, core0_ratio_strap_bit1, core0_ratio_strap_bit2},
        core1:    {core1_ratio_strap_bit0, core1_ratio_strap_bit1, core1_ratio_strap_bit2},
        memory:   {memory_ratio_strap_bit0, memory_ratio_strap_bit1, memory_ratio_strap_bit2}};

    always_comb begin
        status_word = '0;
        status_word[clock_ratio_pkg::STATUS_PLATFORM_CODE_LSB +: 3] = st_reg.codes.platform;
        status_word[clock_ratio_pkg::STATUS_CORE0_CODE_LSB +: 3] = st_reg.codes.core0;
        status_word[clock_ratio_pkg::STATUS_CORE1_CODE_LSB +: 3] = st_reg.codes.core1;
        status_word[clock_ratio_pkg::STATUS_MEMORY_CODE_LSB +: 3] = st_reg.codes.memory;
        status_word[clock_ratio_pkg::STATUS_CAPTURED_BIT] = st_reg.cfg.captured;
        status_word[clock_ratio_pkg::STATUS_PLATFORM_RESERVED_BIT] = st_reg.cfg.platform_reserved;
        status_word[clock_ratio_pkg::STATUS_CORE0_RESERVED_BIT] = st_reg.cfg.core0_reserved;
        status_word[clock_ratio_pkg::STATUS_CORE1_RESERVED_BIT] = st_reg.cfg.core1_reserved;
        status_word[clock_ratio_pkg::STATUS_SYNC_MODE_BIT] = st_reg.cfg.memory_sync_mode;
        ratio_word = '0;
        ratio_word[clock_ratio_pkg::RATIO_PLATFORM_LSB +: 8] = st_reg.cfg.platform_ratio;
        ratio_word[clock_ratio_pkg::RATIO_CORE0_LSB +: 8] = st_reg.cfg.core0_ratio_x2;
        ratio_word[clock_ratio_pkg::RATIO_CORE1_LSB +: 8] = st_reg.cfg.core1_ratio_x2;
        ratio_word[clock_ratio_pkg::RATIO_MEMORY_LSB +: 8] = st_reg.cfg.memory_ratio;
    end

    always_comb begin
        st_next = st_reg;

        // Straps are board levels, unrelated to aclk
        st_next.meta = pins;
        st_next.sync = st_reg.meta;

        // Sample only once the synchroniser has filled after release
        if (!st_reg.cfg.captured) begin
            if (st_reg.settle_cnt != clock_ratio_pkg::STRAP_SETTLE_CYCLES) begin
                st_next.settle_cnt = st_reg.settle_cnt + 2'h1;
            end else begin
                st_next.codes = st_reg.sync;
                st_next.cfg.captured = 1'b1;
                st_next.cfg.platform_ratio =
                    clock_ratio_pkg::PLATFORM_RATIO_TABLE[st_reg.sync.platform];
                st_next.cfg.platform_reserved = (st_reg.sync.platform[2:1] == 2'h3);
                st_next.cfg.core0_ratio_x2 =
                    clock_ratio_pkg::CORE_RATIO_X2_TABLE[st_reg.sync.core0];
                st_next.cfg.core0_reserved = (st_reg.sync.core0 < 3'h3);
                st_next.cfg.core1_ratio_x2 =
                    clock_ratio_pkg::CORE_RATIO_X2_TABLE[st_reg.sync.core1];
                st_next.cfg.core1_reserved = (st_reg.sync.core1 < 3'h3);
                st_next.cfg.memory_ratio =
                    clock_ratio_pkg::MEMORY_RATIO_TABLE[st_reg.sync.memory];
                st_next.cfg.memory_sync_mode =
                    (st_reg.sync.memory == clock_ratio_pkg::MEMORY_SYNC_CODE);
            end
        end

        // Synchronous mode: aclk stands for the platform clock, halved here
        if (st_reg.cfg.captured && st_reg.cfg.memory_sync_mode && st_reg.mem_clk_enable) begin
            st_next.mck = ~st_reg.mck;
        end else begin
            st_next.mck = 1'b0;
        end

        // Write path: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            if (st_reg.awaddr[3:2] == clock_ratio_pkg::CLOCK_CONTROL_OFFSET[3:2]) begin
                st_next.bresp = clock_ratio_pkg::RESP_OKAY;
                if (st_reg.wstrb0) begin
                    st_next.mem_clk_enable =
                        st_reg.wdata[clock_ratio_pkg::CONTROL_MEMORY_CLOCK_ENABLE_BIT];
                end
            end else begin
                // Read-only and unmapped words refuse writes
                st_next.bresp = clock_ratio_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // Read path: one outstanding read, answered the cycle after address
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = clock_ratio_pkg::RESP_OKAY;
            case (s_axi_araddr[3:2])
                clock_ratio_pkg::STRAP_STATUS_OFFSET[3:2]: begin
                    st_next.rdata = status_word;
                end
                clock_ratio_pkg::CLOCK_CONTROL_OFFSET[3:2]: begin
                    st_next.rdata = {31'h0, st_reg.mem_clk_enable};
                end
                clock_ratio_pkg::RATIO_OFFSET[3:2]: begin
                    st_next.rdata = ratio_word;
                end
                default: begin
                    st_next.rdata = '0;
                    st_next.rresp = clock_ratio_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign clock_config = st_reg.cfg;
    // One clock feeds every memory controller, so modes can never differ
    assign memory_bus_clock_out = st_reg.mck;
    // Asynchronous mode hands the DDR rate to the reference-clock PLL
    assign memory_pll_enable = st_reg.cfg.captured && !st_reg.cfg.memory_sync_mode
                               && st_reg.mem_clk_enable;
    assign s_axi_awready = !st_reg.aw_held;
    assign s_axi_wready = !st_reg.w_held;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

endmodule

`default_nettype wire

// >>> verif/clock_ratio_chk.sv
// Output checks for the clock ratio strap decoder
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_chk (
    input wire logic                           aclk,
    input wire logic                           aresetn,
    input wire clock_ratio_pkg::clock_config_t clock_config,
    input wire logic                           memory_bus_clock_out,
    input wire logic                           memory_pll_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_hold; clock_config.captured |=> $stable(clock_config); endproperty
    a_hold: assert property (p_hold) else $error("config moved after capture");
    // Window allows for the two-flop strap synchroniser
    property p_cap;
        $rose(aresetn) |-> !clock_config.captured ##[2:4] clock_config.captured;
    endproperty
    a_cap: assert property (p_cap) else $error("strap capture late");
    property p_toggle;
        clock_config.memory_sync_mode && memory_bus_clock_out |=> !memory_bus_clock_out;
    endproperty
    a_toggle: assert property (p_toggle) else $error("memory clock not halved");
    property p_async_idle;
        clock_config.captured && !clock_config.memory_sync_mode |-> !memory_bus_clock_out;
    endproperty
    a_async_idle: assert property (p_async_idle) else $error("clock out in async");
    property p_pll;
        memory_pll_enable |-> clock_config.captured && !clock_config.memory_sync_mode;
    endproperty
    a_pll: assert property (p_pll) else $error("pll enabled in sync mode");
    property p_sync;
        clock_config.captured |->
            clock_config.memory_sync_mode == (clock_config.memory_ratio == 8'h00);
    endproperty
    a_sync: assert property (p_sync) else $error("sync flag and ratio disagree");
    property p_plat_res;
        clock_config.captured |->
            clock_config.platform_reserved == (clock_config.platform_ratio == 8'h00);
    endproperty
    a_plat_res: assert property (p_plat_res) else $error("platform reserved flag");
    property p_core_res;
        clock_config.captured |->
            clock_config.core0_reserved == (clock_config.core0_ratio_x2 == 8'h00)
            && clock_config.core1_reserved == (clock_config.core1_ratio_x2 == 8'h00);
    endproperty
    a_core_res: assert property (p_core_res) else $error("core reserved flag");
endmodule
`default_nettype wire

// >>> verif/strap_board.sv
// Board strap model: pulls straps during reset, pins carry traffic after
`timescale 1ns/10ps
`default_nettype none
module strap_board (
    input  wire logic                          aclk,
    input  wire clock_ratio_pkg::strap_codes_t codes,
    input  wire logic                          strapping,
    output var  clock_ratio_pkg::strap_codes_t pins
);
    logic toggle = 1'b0;

    always @(posedge aclk) toggle <= ~toggle;
    // Every pin driven, no default; one memory code serves both controllers
    assign pins = strapping ? codes : {4{toggle, ~toggle, toggle}};
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the clock ratio strap decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                           aclk = 1'b0;
    logic                           aresetn = 1'b0;
    logic                           strapping = 1'b1;
    clock_ratio_pkg::strap_codes_t  codes = '0;
    clock_ratio_pkg::strap_codes_t  pins;
    clock_ratio_pkg::clock_config_t cfg;
    logic                           mclk;
    logic                           pll_en;
    logic [3:0]                     awaddr = '0;
    logic [3:0]                     araddr = '0;
    logic [31:0]                    wdata = '0;
    logic [31:0]                    rdata;
    logic [1:0]                     bresp;
    logic [1:0]                     rresp;
    logic                           awvalid = 1'b0;
    logic                           wvalid = 1'b0;
    logic                           arvalid = 1'b0;
    logic                           awready, wready, arready, bvalid, rvalid;
    logic                           ready_hi = 1'b1;
    int                             checked = 0;
    int                             miscompares = 0;
    // Strap codes beside the expected ratio register word
    logic [43:0]                    rows [8] = '{{12'h038, 32'h03070004}, {12'h271, 32'h04060005},
        {12'h4aa, 32'h06050006}, {12'h6e3, 32'h08040308}, {12'h91c, 32'h0a03040a},
        {12'hb55, 32'h0c00050c}, {12'hd8e, 32'h0e000600}, {12'hfc7, 32'h00000700}};

    always #4 aclk = ~aclk;

    strap_board strap_board_i (.aclk(aclk), .codes(codes), .strapping(strapping), .pins(pins));
    clock_ratio_strap_decoder clock_ratio_strap_decoder_i (
        .aclk(aclk), .aresetn(aresetn), .platform_ratio_strap(pins.platform),
        .core0_ratio_strap_bit0(pins.core0[2]), .core0_ratio_strap_bit1(pins.core0[1]),
        .core0_ratio_strap_bit2(pins.core0[0]), .core1_ratio_strap_bit0(pins.core1[2]),
        .core1_ratio_strap_bit1(pins.core1[1]), .core1_ratio_strap_bit2(pins.core1[0]),
        .memory_ratio_strap_bit0(pins.memory[2]), .memory_ratio_strap_bit1(pins.memory[1]),
        .memory_ratio_strap_bit2(pins.memory[0]), .clock_config(cfg),
        .memory_bus_clock_out(mclk), .memory_pll_enable(pll_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(ready_hi),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(ready_hi));

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Power-on reset with straps held, then pins go back to other traffic
    task automatic strap_up(input logic [11:0] c);
        int n;
        n = 0;
        codes <= c;
        strapping <= 1'b1;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        while (cfg.captured !== 1'b1 && n < 20) begin
            @(negedge aclk);
            n++;
        end
        @(posedge aclk);
        strapping <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // Handshakes judged on settled values before the edge, acted on after it
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_go, w_go, done;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        done = 1'b0;
        r = '0;
        while (!done) begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, done;
        araddr <= a;
        arvalid <= 1'b1;
        done = 1'b0;
        d = '0;
        r = '0;
        while (!done) begin
            @(negedge aclk);
            ar_go = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
        end
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        finish_test();
    end

    initial begin
        logic [31:0]                   w, d;
        logic [1:0]                    r;
        logic                          s, a;
        clock_ratio_pkg::strap_codes_t c;
        for (int i = 0; i < 8; i++) begin
            w = rows[i][31:0];
            c = rows[i][43:32];
            s = c.memory == 3'h7;
            strap_up(c);
            chk("config", {1'b1, w[7:0], w[7:0] == 0, w[15:8], w[15:8] == 0, w[23:16],
                w[23:16] == 0, w[31:24], s}, cfg);
            axi_read(clock_ratio_pkg::STRAP_STATUS_OFFSET, d, r);
            chk("status", {clock_ratio_pkg::RESP_OKAY, 15'h0, s, w[23:16] == 0, w[15:8] == 0,
                w[7:0] == 0, 1'b1, c.memory, c.core1, c.core0, c.platform}, {r, d});
            axi_read(clock_ratio_pkg::RATIO_OFFSET, d, r);
            chk("ratio reg", {clock_ratio_pkg::RESP_OKAY, w}, {r, d});
            @(negedge aclk);
            a = mclk;
            @(negedge aclk);
            chk("memory clock", {!s, s & !a}, {pll_en, mclk});
            @(posedge aclk);
            $display("row %0d done", i);
        end
        // Last row is sync mode: gate the clock, then try refused accesses
        axi_write(clock_ratio_pkg::CLOCK_CONTROL_OFFSET, 32'h0, r);
        @(negedge aclk);
        a = mclk;
        @(negedge aclk);
        chk("gated clock", {clock_ratio_pkg::RESP_OKAY, 2'b00}, {r, a, mclk});
        @(posedge aclk);
        axi_write(clock_ratio_pkg::STRAP_STATUS_OFFSET, 32'hffffffff, r);
        chk("ro write", clock_ratio_pkg::RESP_SLVERR, r);
        axi_read(4'hc, d, r);
        chk("unmapped", {clock_ratio_pkg::RESP_SLVERR, 32'h0}, {r, d});
        $display("refusal test done");
        // Row 3 as a real board: 66.66 MHz system ref, 83.33 MHz memory ref
        // Platform 533, cores 800/1067, DDR 667 above platform, bus clock 333 MHz
        strap_up(rows[3][43:32]);
        axi_read(clock_ratio_pkg::CLOCK_CONTROL_OFFSET, d, r);
        chk("control reset", {clock_ratio_pkg::RESP_OKAY, 2'b11}, {r, d[0], pll_en});
        axi_write(clock_ratio_pkg::CLOCK_CONTROL_OFFSET, 32'h0, r);
        @(posedge aclk);
        chk("pll off", {clock_ratio_pkg::RESP_OKAY, 2'b00}, {r, pll_en, mclk});
        $display("control test done");
        finish_test();
    end
endmodule

bind clock_ratio_strap_decoder clock_ratio_chk chk_i (.aclk(aclk), .aresetn(aresetn),
    .clock_config(clock_config), .memory_bus_clock_out(memory_bus_clock_out),
    .memory_pll_enable(memory_pll_enable));
`default_nettype wire
